// ---- rtl/ethernet_mac_unit.sv ----
// ethernet mac operation control: transmit fifo, mii link, management, status
//------------------------------------------------------------
// byte fifo
//------------------------------------------------------------
module mac_byte_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   assign in_ready = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign push = in_valid && in_ready && clk_en;
   assign pop = out_valid && out_ready && clk_en;
   assign out_data = mem[rd_ptr];

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

//------------------------------------------------------------
// top
//------------------------------------------------------------
module ethernet_mac_unit (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic clk_en,
   input mac_ctl_pkg::mac_command_s mac_command_reg,
   input wire logic pause_request,
   output logic send_pause_frame,
   input wire logic [15:0] addr_entry_enable,
   input wire logic [47:0] pause_dest_entry,
   input wire logic [47:0] pause_src_entry,
   input wire logic [47:0] pause_ctrl_entry,
   input wire logic [mac_ctl_pkg::ST_BITS-1:0] irq_enable_reg,
   input wire logic [mac_ctl_pkg::ST_BITS-1:0] irq_status_clear,
   output logic [mac_ctl_pkg::ST_BITS-1:0] irq_status_reg,
   output logic irq,
   input wire logic tx_bus_error,
   input wire logic rx_bus_error,
   input wire logic tx_desc_valid,
   input wire logic rx_desc_valid,
   input wire logic tx_start_demand,
   input wire logic rx_start_demand,
   input mac_ctl_pkg::byte_word_s tx_in,
   input wire logic tx_in_valid,
   output logic tx_in_ready,
   output mac_ctl_pkg::byte_word_s rx_out,
   output logic rx_out_valid,
   input mac_ctl_pkg::phy_mgmt_cmd_s phy_mgmt_command_reg,
   input wire logic phy_mgmt_start,
   output logic phy_mgmt_busy,
   output logic [15:0] phy_mgmt_data_reg,
   output logic mdc,
   input wire logic mdio_in,
   output logic mdio_out,
   output logic mdio_oe,
   input wire logic tx_clk,
   output logic [3:0] mii_txd,
   output logic mii_tx_en,
   input wire logic rx_clk,
   input wire logic [3:0] mii_rxd,
   input wire logic mii_rx_dv
);
   import mac_ctl_pkg::*;

   //------------------------------------------------------------
   // pin synchronisers
   //------------------------------------------------------------
   logic [SYNC_BITS-1:0] pin_raw;
   logic [SYNC_BITS-1:0] sync_a;
   logic [SYNC_BITS-1:0] sync_b;
   logic [1:0] clk_prev;
   logic tx_edge;
   logic rx_pin_edge;
   logic rx_edge;
   logic [3:0] rx_nib;
   logic rx_dv;

   // bit order: tx clock, rx clock, rx valid, rx nibble (bits 6:3), management data
   assign pin_raw = {mdio_in, mii_rxd, mii_rx_dv, rx_clk, tx_clk};

   for (genvar i = 0; i < SYNC_BITS; i++) begin : g_sync
      always_ff @(posedge clk_sys) begin
         if (!resetn) begin
            sync_a[i] <= 1'b0;
            sync_b[i] <= 1'b0;
         end else if (clk_en) begin
            sync_a[i] <= pin_raw[i];
            sync_b[i] <= sync_a[i];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         clk_prev <= 2'h0;
      end else if (clk_en) begin
         clk_prev <= sync_b[1:0];
      end
   end

   logic fd_eff;
   assign fd_eff = mac_command_reg.full_duplex_select || mac_command_reg.internal_loopback;
   assign tx_edge = clk_en && sync_b[0] && !clk_prev[0];
   assign rx_pin_edge = clk_en && sync_b[1] && !clk_prev[1];
   // loop-back samples our own transmit outputs on the transmit clock
   assign rx_edge = mac_command_reg.internal_loopback ? tx_edge : rx_pin_edge;
   assign rx_nib = mac_command_reg.internal_loopback ? mii_txd : sync_b[6:3];
   assign rx_dv = mac_command_reg.internal_loopback ? mii_tx_en : sync_b[2];

   //------------------------------------------------------------
   // status flags and interrupt
   //------------------------------------------------------------
   logic tdu_event;
   logic rdu_event;
   logic [ST_BITS-1:0] st_set;
   assign st_set = {rdu_event, tdu_event, rx_bus_error, tx_bus_error};

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         irq_status_reg <= '0;
      end else if (clk_en) begin
         // a new event wins over a clear in the same cycle
         irq_status_reg <= (irq_status_reg & ~irq_status_clear) | st_set;
      end
   end

   assign irq = |(irq_status_reg & irq_enable_reg);

   //------------------------------------------------------------
   // transmit: fifo, pause and mii nibbles
   //------------------------------------------------------------
   byte_word_s fifo_out;
   logic fifo_valid;
   logic fifo_pop;
   tx_state_e tx_state;
   logic tx_half;
   logic tx_stall;
   logic [4:0] pause_cnt;
   logic [143:0] pause_bytes;
   logic [7:0] tx_byte;
   logic pause_go;

   mac_byte_fifo #(.WIDTH($bits(byte_word_s)), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .clk_en(clk_en),
      .in_data(tx_in),
      .in_valid(tx_in_valid),
      .in_ready(tx_in_ready),
      .out_data(fifo_out),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop)
   );

   assign pause_bytes = {pause_dest_entry, pause_src_entry, pause_ctrl_entry};
   assign tx_byte = (tx_state == TX_PAUSE) ? pause_bytes[143 - 8 * pause_cnt -: 8] : fifo_out.data;
   assign pause_go = send_pause_frame && fd_eff && addr_entry_enable[PAUSE_DEST_ENTRY] &&
                     addr_entry_enable[PAUSE_SRC_ENTRY] && addr_entry_enable[PAUSE_CTRL_ENTRY];
   assign fifo_pop = tx_edge && tx_state == TX_FIFO && tx_half && fifo_valid &&
                     mac_command_reg.transmit_enable_bit;
   assign tdu_event = tx_edge && tx_state == TX_IDLE && !pause_go && !tx_stall && fifo_valid &&
                      mac_command_reg.transmit_enable_bit && !tx_desc_valid;

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         tx_stall <= 1'b0;
      end else if (clk_en) begin
         if (tdu_event) begin
            tx_stall <= 1'b1;
         end else if (tx_start_demand) begin
            tx_stall <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         send_pause_frame <= 1'b0;
      end else if (clk_en) begin
         if (tx_edge && tx_state == TX_PAUSE && tx_half && pause_cnt == 5'(PAUSE_BYTES - 1)) begin
            send_pause_frame <= 1'b0;
         end else if (pause_request) begin
            send_pause_frame <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         tx_state <= TX_IDLE;
         tx_half <= 1'b0;
         pause_cnt <= '0;
         mii_tx_en <= 1'b0;
         mii_txd <= 4'h0;
      end else if (tx_edge) begin
         case (tx_state)
            TX_IDLE: begin
               mii_tx_en <= 1'b0;
               tx_half <= 1'b0;
               pause_cnt <= '0;
               if (mac_command_reg.transmit_enable_bit) begin
                  if (pause_go) begin
                     tx_state <= TX_PAUSE;
                  end else if (!tx_stall && fifo_valid && tx_desc_valid) begin
                     tx_state <= TX_FIFO;
                  end
               end
            end
            TX_FIFO, TX_PAUSE: begin
               // dropping transmit enable or running dry ends the frame here
               if (!mac_command_reg.transmit_enable_bit ||
                   (tx_state == TX_FIFO && !fifo_valid)) begin
                  tx_state <= TX_IDLE;
                  mii_tx_en <= 1'b0;
               end else begin
                  mii_tx_en <= 1'b1;
                  mii_txd <= tx_half ? tx_byte[7:4] : tx_byte[3:0];
                  tx_half <= !tx_half;
                  if (tx_half) begin
                     pause_cnt <= pause_cnt + 5'h1;
                     if ((tx_state == TX_FIFO && fifo_out.last) ||
                         (tx_state == TX_PAUSE && pause_cnt == 5'(PAUSE_BYTES - 1))) begin
                        tx_state <= TX_IDLE;
                     end
                  end
               end
            end
            default: tx_state <= TX_IDLE;
         endcase
      end
   end

   //------------------------------------------------------------
   // receive
   //------------------------------------------------------------
   logic rx_act;
   logic rx_drop;
   logic rx_stall;
   logic rx_half;
   logic [3:0] rx_lo;
   logic rx_held;
   logic [7:0] rx_hold;

   assign rdu_event = rx_edge && rx_dv && !rx_act && !rx_drop && !rx_stall &&
                      mac_command_reg.receive_enable_bit && !rx_desc_valid;

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         rx_stall <= 1'b0;
      end else if (clk_en) begin
         if (rdu_event) begin
            rx_stall <= 1'b1;
         end else if (rx_start_demand) begin
            rx_stall <= 1'b0;
         end
      end
   end

   // a byte is held back one step so that the frame end can mark it last
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         rx_act <= 1'b0;
         rx_drop <= 1'b0;
         rx_half <= 1'b0;
         rx_lo <= 4'h0;
         rx_held <= 1'b0;
         rx_hold <= 8'h00;
         rx_out <= '0;
         rx_out_valid <= 1'b0;
      end else if (clk_en) begin
         rx_out_valid <= 1'b0;
         if (rx_edge) begin
            if (!rx_dv) begin
               if (rx_act && rx_held) begin
                  rx_out <= '{last: 1'b1, data: rx_hold};
                  rx_out_valid <= 1'b1;
               end
               rx_act <= 1'b0;
               rx_drop <= 1'b0;
               rx_held <= 1'b0;
            end else if (!rx_act && !rx_drop) begin
               if (!mac_command_reg.receive_enable_bit || rx_stall || !rx_desc_valid) begin
                  rx_drop <= 1'b1;
               end else begin
                  rx_act <= 1'b1;
                  rx_lo <= rx_nib;
                  rx_half <= 1'b1;
               end
            end else if (rx_act && !mac_command_reg.receive_enable_bit) begin
               rx_act <= 1'b0;
               rx_drop <= 1'b1;
               rx_held <= 1'b0;
            end else if (rx_act) begin
               rx_half <= !rx_half;
               if (rx_half) begin
                  rx_hold <= {rx_nib, rx_lo};
                  rx_held <= 1'b1;
                  if (rx_held) begin
                     rx_out <= '{last: 1'b0, data: rx_hold};
                     rx_out_valid <= 1'b1;
                  end
               end else begin
                  rx_lo <= rx_nib;
               end
            end
         end
      end
   end

   //------------------------------------------------------------
   // phy management
   //------------------------------------------------------------
   logic [MGMT_FRAME_BITS-1:0] mgmt_shift;
   logic [5:0] mgmt_bit;
   logic mgmt_wr;
   logic [7:0] mdc_div;

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         phy_mgmt_busy <= 1'b0;
         mgmt_shift <= '0;
         mgmt_bit <= '0;
         mgmt_wr <= 1'b0;
         mdc_div <= '0;
         mdc <= 1'b0;
         phy_mgmt_data_reg <= 16'h0000;
      end else if (clk_en) begin
         if (!mac_command_reg.mgmt_clock_enable) begin
            mdc <= 1'b0;
            mdc_div <= '0;
         end else if (mdc_div == 8'(MDC_HALF_CYC - 1)) begin
            mdc_div <= '0;
            mdc <= !mdc;
            if (!mdc && phy_mgmt_busy && !mgmt_wr && mgmt_bit >= 6'(MGMT_DATA_BIT)) begin
               phy_mgmt_data_reg <= {phy_mgmt_data_reg[14:0], sync_b[7]};
            end
            if (mdc && phy_mgmt_busy) begin
               mgmt_shift <= {mgmt_shift[MGMT_FRAME_BITS-2:0], 1'b0};
               mgmt_bit <= mgmt_bit + 6'h1;
               if (mgmt_bit == 6'(MGMT_FRAME_BITS - 1)) begin
                  phy_mgmt_busy <= 1'b0;
               end
            end
         end else begin
            mdc_div <= mdc_div + 8'h1;
         end
         if (phy_mgmt_start && !phy_mgmt_busy) begin
            phy_mgmt_busy <= 1'b1;
            mgmt_wr <= phy_mgmt_command_reg.write;
            mgmt_bit <= '0;
            mgmt_shift <= {32'hFFFFFFFF, MGMT_START,
                           phy_mgmt_command_reg.write ? MGMT_OP_WR : MGMT_OP_RD,
                           phy_mgmt_command_reg.phy, phy_mgmt_command_reg.regnum,
                           MGMT_TA_WR, phy_mgmt_command_reg.data};
         end
      end
   end

   assign mdio_out = mgmt_shift[MGMT_FRAME_BITS-1];
   assign mdio_oe = phy_mgmt_busy && (mgmt_wr || mgmt_bit < 6'(MGMT_TA_BIT));

   //------------------------------------------------------------
   // checks
   //------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   sequence pause_start;
      $rose(tx_state == TX_PAUSE);
   endsequence

   a_tx_only_on: assert property ($rose(mii_tx_en) |-> $past(mac_command_reg.transmit_enable_bit))
      else $error("transmit started without transmit enable");
   a_rx_only_on: assert property ($rose(rx_act) |-> $past(mac_command_reg.receive_enable_bit))
      else $error("receive started without receive enable");
   a_irq_mask_gate: assert property ((irq_status_reg & irq_enable_reg) == '0 |-> !irq)
      else $error("interrupt raised for a masked status");
   a_bus_err_flag: assert property (clk_en && rx_bus_error |=> irq_status_reg[ST_RX_BUS_ERROR_FLAG])
      else $error("receive bus error not flagged");
   a_tdu_on_stall: assert property ($rose(tx_stall) |-> irq_status_reg[ST_TDU])
      else $error("transmit stall without unavailable flag");
   a_resume_on_demand: assert property ($fell(rx_stall) |-> $past(rx_start_demand))
      else $error("receive resumed without start demand");
   a_pause_full_dup: assert property (pause_start |-> $past(fd_eff))
      else $error("pause frame started in half duplex");
   a_pause_self_clear: assert property (pause_start ##1 (tx_state == TX_PAUSE) [*2]
      |-> send_pause_frame)
      else $error("send pause cleared before frame sent");
   a_pause_end_clear: assert property ($fell(send_pause_frame) |-> $past(tx_state == TX_PAUSE))
      else $error("send pause cleared outside pause frame");
   a_status_sticky: assert property (irq_status_reg[ST_TDU] && !irq_status_clear[ST_TDU] && clk_en
      |=> irq_status_reg[ST_TDU])
      else $error("status flag dropped without clear");
endmodule

// ---- rtl/mac_ctl_pkg.sv ----
// package: constants, types and carriers of the ethernet mac operation control block
//------------------------------------------------------------
// Behaviour
// - phy management reads and writes go through the management data and command ports.
// - frames are sent only with transmit enable, received only with receive enable.
// - interrupt raised only for status bits enabled in the interrupt enable register.
// - failed memory access sets the transmit or receive bus error flag.
// - missing valid transmit or receive descriptor sets the matching unavailable flag.
// - after a descriptor stall, traffic resumes only on a start demand write.
// - pause frames are sent only in full duplex.
// - pause frame built from entries 13 (dest), 14 (source), 15 (type, opcode, operand).
// - send pause bit starts pause transmission and clears itself when sent.
// - loop-back sends transmit data into receive and forces full duplex.
//------------------------------------------------------------
package mac_ctl_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int MDC_PERIOD_NS = 400;
   // least half period of the management clock, rounded up
   localparam int MDC_HALF_CYC = (MDC_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
   localparam int MGMT_FRAME_BITS = 64;
   localparam int MGMT_TA_BIT = 46;
   localparam int MGMT_DATA_BIT = 48;
   localparam logic [1:0] MGMT_START = 2'h1;
   localparam logic [1:0] MGMT_OP_WR = 2'h1;
   localparam logic [1:0] MGMT_OP_RD = 2'h2;
   localparam logic [1:0] MGMT_TA_WR = 2'h2;
   localparam int PAUSE_BYTES = 18;
   localparam int PAUSE_DEST_ENTRY = 13;
   localparam int PAUSE_SRC_ENTRY = 14;
   localparam int PAUSE_CTRL_ENTRY = 15;
   localparam int FIFO_DEPTH = 8;
   localparam int ST_TX_BUS_ERROR_FLAG = 0;
   localparam int ST_RX_BUS_ERROR_FLAG = 1;
   localparam int ST_TDU = 2;
   localparam int ST_RDU = 3;
   localparam int ST_BITS = 4;
   localparam int SYNC_BITS = 8;

   typedef struct packed {
      logic last;
      logic [7:0] data;
   } byte_word_s;

   typedef struct packed {
      logic transmit_enable_bit;
      logic receive_enable_bit;
      logic mgmt_clock_enable;
      logic full_duplex_select;
      logic internal_loopback;
   } mac_command_s;

   typedef struct packed {
      logic write;
      logic [4:0] phy;
      logic [4:0] regnum;
      logic [15:0] data;
   } phy_mgmt_cmd_s;

   typedef enum {TX_IDLE, TX_FIFO, TX_PAUSE} tx_state_e;
endpackage

// ---- dv/phy_model.sv ----
// phy partner model: mii transmit capture, mii receive source, management responder
module phy_model (
   input wire logic run,
   output logic tx_clk,
   output logic rx_clk,
   input wire logic [3:0] mii_txd,
   input wire logic mii_tx_en,
   output logic [3:0] mii_rxd,
   output logic mii_rx_dv,
   input wire logic mdc,
   input wire logic mdio_out,
   input wire logic mdio_oe,
   output logic mdio_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] rd_data = 16'hA5C3;
   logic [3:0] txq[$];
   int rises = 0;
   logic drv = 1'b1;
   initial begin
      tx_clk = 1'b0;
      rx_clk = 1'b0;
      mii_rxd = 4'h0;
      mii_rx_dv = 1'b0;
   end
   // transmit clock halts low while the bench has no traffic running
   always begin
      #62.5;
      if (run || tx_clk) tx_clk = ~tx_clk;
   end
   // mid-period sample: the mac updates its outputs a few system clocks after the edge
   always @(negedge tx_clk) if (mii_tx_en === 1'b1) txq.push_back(mii_txd);
   //------------------------------------------------------------
   // management responder
   //------------------------------------------------------------
   // released wire has a pull-up, so it reads one unless someone drives it
   assign mdio_in = (mdio_oe === 1'b1) ? mdio_out : drv;
   always @(posedge mdc) rises = (mdio_oe === 1'b1) ? 0 : rises + 1;
   // read data placed after turnaround, changed only while mdc is low
   always @(negedge mdc) begin
      drv = (mdio_oe !== 1'b1 && rises >= 2 && rises <= 17) ? rd_data[17 - rises] : 1'b1;
   end
   //------------------------------------------------------------
   // receive source: bytes low nibble first, clock only within the frame and for one period after it
   //------------------------------------------------------------
   task automatic rx_send(input logic [15:0] b);
      for (int i = 0; i < 4; i++) begin
         mii_rxd = b[4*i +: 4];
         mii_rx_dv = 1'b1;
         #62.5 rx_clk = 1'b1;
         #62.5 rx_clk = 1'b0;
      end
      mii_rx_dv = 1'b0;
      mii_rxd = ~mii_rxd;
      #62.5 rx_clk = 1'b1;
      #62.5 rx_clk = 1'b0;
   endtask
endmodule

// ---- dv/ethernet_mac_operation_control_bench.sv ----
// self-checking bench of the ethernet mac operation control block
module ethernet_mac_operation_control_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import mac_ctl_pkg::*;
   typedef struct packed {logic tb; logic rb; logic [3:0] en; logic [3:0] st; logic irq;} row_s;
   row_s rows[3] = '{'{1'b1, 1'b0, 4'h1, 4'h1, 1'b1}, '{1'b0, 1'b1, 4'h1, 4'h2, 1'b0},
      '{1'b1, 1'b1, 4'h2, 4'h3, 1'b1}};
   logic clk_sys = 1'b0, resetn = 1'b0, clk_en = 1'b1, run = 1'b0;
   mac_command_s mac_command_reg = '0;
   phy_mgmt_cmd_s phy_mgmt_command_reg = '0;
   byte_word_s tx_in = '0, rx_out;
   logic pause_request = 1'b0, send_pause_frame, irq, tx_in_valid = 1'b0, tx_in_ready;
   logic [15:0] addr_entry_enable = 16'h0, phy_mgmt_data_reg;
   logic [47:0] pause_dest_entry = 48'h0123456789AB, pause_src_entry = 48'hCDEF01234567;
   logic [47:0] pause_ctrl_entry = 48'h8808000100FF;
   logic [3:0] irq_enable_reg = 4'h0, irq_status_clear = 4'h0, irq_status_reg, mii_txd, mii_rxd;
   logic tx_bus_error = 1'b0, rx_bus_error = 1'b0, tx_desc_valid = 1'b1, rx_desc_valid = 1'b1;
   logic tx_start_demand = 1'b0, rx_start_demand = 1'b0, rx_out_valid, phy_mgmt_start = 1'b0;
   logic phy_mgmt_busy, mdc, mdio_in, mdio_out, mdio_oe, tx_clk, mii_tx_en, rx_clk, mii_rx_dv;
   logic [7:0] bq[$];
   logic [143:0] pz;
   byte_word_s rxq[$];
   int num_errors = 0, checks_done = 0, acc;
   always #5 clk_sys = ~clk_sys;
   ethernet_mac_unit u_dut (.clk_sys, .resetn, .clk_en, .mac_command_reg, .pause_request,
      .send_pause_frame, .addr_entry_enable, .pause_dest_entry, .pause_src_entry,
      .pause_ctrl_entry, .irq_enable_reg, .irq_status_clear, .irq_status_reg, .irq,
      .tx_bus_error, .rx_bus_error, .tx_desc_valid, .rx_desc_valid, .tx_start_demand,
      .rx_start_demand, .tx_in, .tx_in_valid, .tx_in_ready, .rx_out, .rx_out_valid,
      .phy_mgmt_command_reg, .phy_mgmt_start, .phy_mgmt_busy, .phy_mgmt_data_reg, .mdc,
      .mdio_in, .mdio_out, .mdio_oe, .tx_clk, .mii_txd, .mii_tx_en, .rx_clk, .mii_rxd,
      .mii_rx_dv);
   phy_model u_phy (.run, .tx_clk, .rx_clk, .mii_txd, .mii_tx_en, .mii_rxd, .mii_rx_dv, .mdc,
      .mdio_out, .mdio_oe, .mdio_in);
   always @(posedge clk_sys) if (rx_out_valid === 1'b1) rxq.push_back(rx_out);
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic fin(input string name);
      $display("test %s finished", name);
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // holds valid across the words, lowers it only after the last is taken
   task automatic push(input logic [8:0] ws[$]);
      foreach (ws[i]) begin
         tx_in <= ws[i];
         tx_in_valid <= 1'b1;
         for (int k = 0; k < 50; k++) begin
            @(negedge clk_sys);
            if (tx_in_ready === 1'b1) break;
         end
         @(posedge clk_sys);
      end
      tx_in_valid <= 1'b0;
   endtask
   // waits for the frame on the wire, then compares nibbles, low half of each byte first
   task automatic tx_exp();
      for (int k = 0; k < 3000; k++) begin
         @(posedge clk_sys);
         if (u_phy.txq.size() >= 2 * bq.size() && mii_tx_en === 1'b0) break;
      end
      chk(u_phy.txq.size(), 2 * bq.size());
      foreach (bq[i]) begin
         chk(u_phy.txq[2*i], bq[i][3:0]);
         chk(u_phy.txq[2*i+1], bq[i][7:4]);
      end
      u_phy.txq.delete();
      bq.delete();
   endtask
   initial begin
      #400us;
      num_errors++;
      give_verdict();
   end
   initial begin
      cyc(16);
      resetn <= 1'b1;
      chk({irq_status_reg, send_pause_frame, phy_mgmt_busy, tx_in_ready, irq}, 8'h02);
      run <= 1'b1;
      mac_command_reg <= 5'b11110;
      addr_entry_enable <= 16'hE000;
      fin("reset");
      foreach (rows[i]) begin
         irq_enable_reg <= rows[i].en;
         tx_bus_error <= rows[i].tb;
         rx_bus_error <= rows[i].rb;
         @(posedge clk_sys);
         tx_bus_error <= 1'b0;
         rx_bus_error <= 1'b0;
         cyc(6);
         chk(irq_status_reg, rows[i].st);
         chk(irq, rows[i].irq);
         irq_status_clear <= 4'hF;
         cyc(1);
         irq_status_clear <= 4'h0;
         cyc(2);
         chk(irq_status_reg, 4'h0);
      end
      // a frozen clock enable must swallow the error pulse
      clk_en <= 1'b0;
      tx_bus_error <= 1'b1;
      cyc(1);
      tx_bus_error <= 1'b0;
      cyc(2);
      clk_en <= 1'b1;
      chk(irq_status_reg, 4'h0);
      irq_enable_reg <= 4'hF;
      fin("status");
      phy_mgmt_command_reg <= '{write: 1'b0, phy: 5'h01, regnum: 5'h02, data: 16'h0};
      phy_mgmt_start <= 1'b1;
      cyc(1);
      phy_mgmt_start <= 1'b0;
      cyc(2);
      chk(phy_mgmt_busy, 1'b1);
      for (int k = 0; k < 3000 && phy_mgmt_busy !== 1'b0; k++) cyc(1);
      chk(phy_mgmt_data_reg, 16'hA5C3);
      fin("management");
      push('{9'h03C, 9'h1A5});
      bq = '{8'h3C, 8'hA5};
      tx_exp();
      fin("transmit");
      mac_command_reg.transmit_enable_bit <= 1'b0;
      acc = 0;
      tx_in_valid <= 1'b1;
      repeat (12) begin
         tx_in <= {acc == 7, 8'h10 + acc[7:0]};
         @(negedge clk_sys);
         if (tx_in_ready === 1'b1) acc++;
         @(posedge clk_sys);
      end
      tx_in_valid <= 1'b0;
      cyc(30);
      chk(acc, FIFO_DEPTH);
      chk(u_phy.txq.size(), 0);
      mac_command_reg.transmit_enable_bit <= 1'b1;
      for (int i = 0; i < 8; i++) bq.push_back(8'h10 + i[7:0]);
      tx_exp();
      fin("fifo");
      tx_desc_valid <= 1'b0;
      push('{9'h17E});
      cyc(100);
      chk(irq_status_reg[ST_TDU], 1'b1);
      tx_desc_valid <= 1'b1;
      cyc(100);
      chk(u_phy.txq.size(), 0);
      tx_start_demand <= 1'b1;
      cyc(1);
      tx_start_demand <= 1'b0;
      bq = '{8'h7E};
      tx_exp();
      fin("descriptor");
      mac_command_reg.full_duplex_select <= 1'b0;
      pause_request <= 1'b1;
      cyc(1);
      pause_request <= 1'b0;
      cyc(200);
      chk({send_pause_frame, u_phy.txq.size() == 0}, 2'h3);
      mac_command_reg.full_duplex_select <= 1'b1;
      pz = {pause_dest_entry, pause_src_entry, pause_ctrl_entry};
      for (int i = 0; i < 18; i++) bq.push_back(pz[143 - 8*i -: 8]);
      tx_exp();
      chk(send_pause_frame, 1'b0);
      fin("pause");
      mac_command_reg <= 5'b11101;
      rxq.delete();
      push('{9'h03C, 9'h1A5});
      cyc(400);
      chk(rxq.size(), 2);
      chk({rxq[0], rxq[1]}, {9'h03C, 9'h1A5});
      fin("loopback");
      mac_command_reg <= 5'b10110;
      u_phy.txq.delete();
      rxq.delete();
      u_phy.rx_send(16'hB29D);
      cyc(30);
      chk(rxq.size(), 0);
      mac_command_reg.receive_enable_bit <= 1'b1;
      cyc(2);
      u_phy.rx_send(16'hB29D);
      cyc(30);
      chk({rxq.size() == 2, rxq[0], rxq[1]}, {1'b1, 9'h09D, 9'h1B2});
      fin("receive");
      rxq.delete();
      rx_desc_valid <= 1'b0;
      cyc(2);
      u_phy.rx_send(16'hB29D);
      cyc(30);
      rx_desc_valid <= 1'b1;
      chk({irq_status_reg[ST_RDU], rxq.size() == 0}, 2'h3);
      cyc(2);
      u_phy.rx_send(16'hB29D);
      cyc(30);
      chk(rxq.size(), 0);
      rx_start_demand <= 1'b1;
      cyc(1);
      rx_start_demand <= 1'b0;
      u_phy.rx_send(16'hB29D);
      cyc(30);
      chk(rxq.size(), 2);
      fin("rx descriptor");
      give_verdict();
   end
endmodule
